// ---- hdl/isr_top.sv ----
// Purpose: status condition, event and enable registers, error queue
// Assumes: commands arrive one per cycle from same-clock parser logic
// Notes:   power-on clear flag and masks live in external non-volatile store
//
// Functional notes
// RL1 - operation event latches condition changes, sticky
// RL2 - only bit 8 used: filter enabled and settled
// RL3 - condition bit refreshed on every measurement
// RL4 - operation event cleared by clear-status or read
// RL5 - operation enable cleared: power-on, preset, write 0
// RL6 - error queue: 20 entries, 80 chars, FIFO
// RL7 - queries return binary-weighted sum of set bits
// RL8 - only enabled event bits reach status byte
// RL9 - preset zeroes questionable and operation enables
// RL10 - clear-status zeroes summary and all events
// RL11 - operation-complete command sets standard event bit 0
// RL12 - operation-complete query replies value 1
// RL13 - power-on flag decides clearing status/event masks
// RL14 - standard event cleared by clear-status or read
// RL15 - latch on 0-to-1; latch beats clear
`timescale 1ns/1ps
module isr_top
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire isr_pkg::isr_cmd_t cmd,
    input  wire logic              meas_done,
    input  wire logic              filter_on,
    input  wire logic              filter_settled,
    input  wire logic [15:0]       ques_cond_in,
    input  wire logic [7:0]        std_evt_set,
    input  wire logic              mav,
    input  wire logic              err_push,
    input  wire isr_pkg::isr_err_t err_in,
    input  wire logic              psc_saved,
    input  wire logic [7:0]        ese_saved,
    input  wire logic [7:0]        sre_saved,
    output      isr_pkg::isr_rsp_t rsp,
    output      logic [7:0]        status_byte,
    output      logic              srq,
    output      logic              psc_flag,
    output      logic [7:0]        ese_mask,
    output      logic [7:0]        sre_mask,
    output      logic [4:0]        err_count
);
    import isr_pkg::*;

    // checks below share one clock and are off while in reset
    default clocking isr_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // =====================================================================
    // state and helpers
    isr_state_t        s_r;
    isr_state_t        s_nxt;
    logic              settle_now;
    logic [OPER_W-1:0] rise_oper;
    logic [QUES_W-1:0] rise_ques;
    logic              cmd_ok;

    // decode a taken command of one kind
    function automatic logic cmd_is(input isr_cmd_t c, input logic pend,
                                    input isr_code_t k);
        cmd_is = c.valid && !pend && (c.code == k);
    endfunction

    // queue index wrap
    function automatic logic [ERR_IW-1:0] idx_inc(input logic [ERR_IW-1:0] i);
        if (i == ERR_IW'(ERR_DEPTH - 1))
            idx_inc = '0;
        else
            idx_inc = i + 1'b1;
    endfunction

    assign settle_now = filter_on & filter_settled;
    assign cmd_ok     = cmd.valid && !s_r.por_pend;

    // =====================================================================
    // next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rsp.valid = 1'b0;
        // condition bit follows the latest measurement only
        if (meas_done)
        begin
            s_nxt.oper_cond = REG16_RST;                    // [RL2]
            s_nxt.oper_cond[OPER_SETTLED_BIT] = settle_now; // [RL2] [RL3]
        end
        s_nxt.ques_cond = ques_cond_in;
        rise_oper = s_nxt.oper_cond & ~s_r.oper_cond;       // [RL15]
        rise_ques = ques_cond_in & ~s_r.ques_cond;
        // error queue push, dropped when full
        if (err_push && s_r.cnt != ERR_IW'(ERR_DEPTH))
        begin
            s_nxt.mem[s_r.wr_idx] = err_in;                 // [RL6]
            s_nxt.wr_idx = idx_inc(s_r.wr_idx);
            s_nxt.cnt = s_nxt.cnt + 1'b1;
        end
        if (s_r.por_pend)
        begin
            // first cycle after power-on: restore or clear masks
            s_nxt.por_pend = 1'b0;
            s_nxt.psc = psc_saved;
            s_nxt.std_en = psc_saved ? REG8_RST : ese_saved; // [RL13]
            s_nxt.sre = psc_saved ? REG8_RST : sre_saved;    // [RL13]
            s_nxt.std_evt[STD_PON_BIT] = 1'b1;
        end
        else if (cmd.valid)
        begin
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.data = 16'h0000;
            s_nxt.rsp.err = '0;
            // register values are returned as plain binary sums [RL7]
            case (cmd.code)
                ISR_CMD_CLS:
                begin
                    s_nxt.oper_evt = REG16_RST;             // [RL4] [RL10]
                    s_nxt.ques_evt = REG16_RST;             // [RL10]
                    s_nxt.std_evt = REG8_RST;               // [RL10] [RL14]
                    s_nxt.rsp.valid = 1'b0;
                end
                ISR_CMD_ESE_WR: s_nxt.std_en = cmd.data[7:0];
                ISR_CMD_ESE_RD: s_nxt.rsp.data = {8'h00, s_r.std_en};
                ISR_CMD_ESR_RD:
                begin
                    s_nxt.rsp.data = {8'h00, s_r.std_evt};  // [RL7]
                    s_nxt.std_evt = REG8_RST;               // [RL14]
                end
                ISR_CMD_OPC:
                begin
                    s_nxt.std_evt[STD_OPC_BIT] = 1'b1;      // [RL11]
                    s_nxt.rsp.valid = 1'b0;
                end
                ISR_CMD_OPC_RD: s_nxt.rsp.data = OPC_REPLY; // [RL12]
                ISR_CMD_PSC_WR: s_nxt.psc = cmd.data[0];
                ISR_CMD_PSC_RD: s_nxt.rsp.data = {15'h0000, s_r.psc};
                ISR_CMD_SRE_WR: s_nxt.sre = cmd.data[7:0];
                ISR_CMD_SRE_RD: s_nxt.rsp.data = {8'h00, s_r.sre};
                ISR_CMD_PRESET:
                begin
                    s_nxt.ques_en = REG16_RST;              // [RL9]
                    s_nxt.oper_en = REG16_RST;              // [RL5] [RL9]
                    s_nxt.rsp.valid = 1'b0;
                end
                ISR_CMD_QCOND_RD: s_nxt.rsp.data = s_r.ques_cond;
                ISR_CMD_QEVT_RD:
                begin
                    s_nxt.rsp.data = s_r.ques_evt;
                    s_nxt.ques_evt = REG16_RST;
                end
                ISR_CMD_QEN_WR: s_nxt.ques_en = cmd.data;
                ISR_CMD_QEN_RD: s_nxt.rsp.data = s_r.ques_en;
                ISR_CMD_OCOND_RD: s_nxt.rsp.data = s_r.oper_cond; // [RL7]
                ISR_CMD_OEVT_RD:
                begin
                    s_nxt.rsp.data = s_r.oper_evt;          // [RL7]
                    s_nxt.oper_evt = REG16_RST;             // [RL4]
                end
                ISR_CMD_OEN_WR: s_nxt.oper_en = cmd.data;   // [RL5]
                ISR_CMD_OEN_RD: s_nxt.rsp.data = s_r.oper_en;
                ISR_CMD_ERR_RD:
                begin
                    // oldest entry first; empty queue answers length 0
                    if (s_r.cnt != '0)
                    begin
                        s_nxt.rsp.err = s_r.mem[s_r.rd_idx]; // [RL6]
                        s_nxt.rd_idx = idx_inc(s_r.rd_idx);
                        s_nxt.cnt = s_nxt.cnt - 1'b1;
                    end
                end
                default: s_nxt.rsp.valid = 1'b0;
            endcase
        end
        // hardware sets come last so they win over any clear
        s_nxt.oper_evt = s_nxt.oper_evt | rise_oper;        // [RL1] [RL15]
        s_nxt.ques_evt = s_nxt.ques_evt | rise_ques;
        s_nxt.std_evt = s_nxt.std_evt | (std_evt_set & STD_USED_MASK);
        // summaries see only enabled event bits
        s_nxt.stb = REG8_RST;
        s_nxt.stb[STB_QUES_BIT] = |(s_nxt.ques_evt & s_nxt.ques_en); // [RL8]
        s_nxt.stb[STB_MAV_BIT] = mav;
        s_nxt.stb[STB_ESB_BIT] = |(s_nxt.std_evt & s_nxt.std_en);    // [RL8]
        s_nxt.stb[STB_OPER_BIT] = |(s_nxt.oper_evt & s_nxt.oper_en); // [RL8]
        s_nxt.srq = |(s_nxt.stb & s_nxt.sre);
        s_nxt.stb[STB_RQS_BIT] = s_nxt.srq;
    end

    // =====================================================================
    // state register; power-on leaves a restore step pending
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_r <= '0;                                      // [RL5]
            s_r.por_pend <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // =====================================================================
    // outputs straight from the state register
    assign rsp         = s_r.rsp;
    assign status_byte = s_r.stb;
    assign srq         = s_r.srq;
    assign psc_flag    = s_r.psc;
    assign ese_mask    = s_r.std_en;
    assign sre_mask    = s_r.sre;
    assign err_count   = s_r.cnt;

    // =====================================================================
    // checks
    sequence seq_oevt_rd;
        cmd_is(cmd, s_r.por_pend, ISR_CMD_OEVT_RD) ##0 (rise_oper == '0);
    endsequence

    sequence seq_cls_quiet;
        cmd_is(cmd, s_r.por_pend, ISR_CMD_CLS) ##0 (rise_oper == '0)
            ##0 (rise_ques == '0) ##0 (std_evt_set == 8'h00);
    endsequence

    sequence seq_por_restore;
        s_r.por_pend ##1 !s_r.por_pend;
    endsequence

    AST_ONLY_BIT8: assert property ( // [RL2]
        ((s_r.oper_cond | s_r.oper_evt) & ~OPER_USED_MASK) == '0)
        else $error("unused operation bit set");

    AST_COND_TRACK: assert property ( // [RL3]
        meas_done |=> s_r.oper_cond[OPER_SETTLED_BIT] == $past(settle_now))
        else $error("condition bit did not follow measurement");

    AST_LATCH_WINS: assert property ( // [RL15]
        (meas_done && settle_now && !s_r.oper_cond[OPER_SETTLED_BIT])
        |=> s_r.oper_evt[OPER_SETTLED_BIT])
        else $error("rising settle not latched");

    AST_EVT_STICKY: assert property ( // [RL1]
        (s_r.oper_evt[OPER_SETTLED_BIT]
         && !cmd_is(cmd, s_r.por_pend, ISR_CMD_CLS)
         && !cmd_is(cmd, s_r.por_pend, ISR_CMD_OEVT_RD))
        |=> s_r.oper_evt[OPER_SETTLED_BIT])
        else $error("operation event lost without clear");

    AST_OEVT_READ: assert property ( // [RL4]
        seq_oevt_rd |=> s_r.rsp.valid && s_r.rsp.data == $past(s_r.oper_evt)
                        && s_r.oper_evt == '0)
        else $error("event read wrong value or not cleared");

    AST_PRESET: assert property ( // [RL9]
        cmd_is(cmd, s_r.por_pend, ISR_CMD_PRESET)
        |=> s_r.oper_en == '0 && s_r.ques_en == '0 && !s_r.rsp.valid)
        else $error("preset left enable bits");

    AST_CLS: assert property ( // [RL10]
        seq_cls_quiet |=> s_r.oper_evt == '0 && s_r.ques_evt == '0
                          && s_r.std_evt == '0 && !s_r.stb[STB_ESB_BIT])
        else $error("clear-status left event bits");

    AST_OPC: assert property ( // [RL11]
        cmd_is(cmd, s_r.por_pend, ISR_CMD_OPC) |=> s_r.std_evt[STD_OPC_BIT])
        else $error("operation complete bit not set");

    AST_OPC_RD: assert property ( // [RL12]
        cmd_is(cmd, s_r.por_pend, ISR_CMD_OPC_RD)
        |=> s_r.rsp.valid && s_r.rsp.data == OPC_REPLY
            ##1 (!s_r.rsp.valid || $past(cmd_ok)))
        else $error("operation complete query reply wrong");

    AST_PSC_POR: assert property ( // [RL13]
        seq_por_restore |-> s_r.std_en == ($past(psc_saved) ? 8'h00
                                           : $past(ese_saved))
                            && s_r.sre == ($past(psc_saved) ? 8'h00
                                           : $past(sre_saved)))
        else $error("power-on mask restore wrong");

    AST_SUMMARY: assert property ( // [RL8]
        s_r.stb[STB_OPER_BIT] == |(s_r.oper_evt & s_r.oper_en)
        && s_r.stb[STB_QUES_BIT] == |(s_r.ques_evt & s_r.ques_en))
        else $error("summary bit ignores enable mask");

    AST_QUEUE: assert property ( // [RL6]
        (cmd_is(cmd, s_r.por_pend, ISR_CMD_ERR_RD) && s_r.cnt != '0)
        |=> s_r.rsp.err == $past(s_r.mem[s_r.rd_idx])
            && s_r.cnt <= ERR_IW'(ERR_DEPTH))
        else $error("error queue order or depth wrong");

    AST_OEN_POR: assert property ( // [RL5]
        seq_por_restore |-> s_r.oper_en == '0 && s_r.ques_en == '0)
        else $error("power-on left enable bits");

    AST_ESR_READ: assert property ( // [RL14]
        (cmd_is(cmd, s_r.por_pend, ISR_CMD_ESR_RD) && std_evt_set == 8'h00)
        |=> s_r.rsp.data[STD_W-1:0] == $past(s_r.std_evt)
            && s_r.std_evt == '0)
        else $error("standard event read wrong or not cleared");

    AST_OEN_ZERO: assert property ( // [RL5]
        (cmd_is(cmd, s_r.por_pend, ISR_CMD_OEN_WR) && cmd.data == 16'h0000)
        |=> s_r.oper_en == '0)
        else $error("enable write of zero left bits");

    AST_ESB_SRQ: assert property ( // [RL8]
        s_r.stb[STB_ESB_BIT] == |(s_r.std_evt & s_r.std_en)
        && s_r.srq == |(s_r.stb & s_r.sre))
        else $error("summary or request bit ignores mask");

    AST_QUEUE_CAP: assert property ( // [RL6]
        s_r.cnt <= ERR_IW'(ERR_DEPTH))
        else $error("error queue above capacity");

endmodule // isr_top

// ---- hdl/isr_pkg.sv ----
// Purpose: shared constants and types for instrument status reporting
// Assumes: one clock, synchronous active-high reset meaning power-on
// Notes:   register values are plain binary; the host side formats decimal
package isr_pkg;
    // =====================================================================
    // widths and field positions
    localparam int OPER_W           = 16;
    localparam int QUES_W           = 16;
    localparam int STD_W            = 8;
    localparam int STB_W            = 8;
    localparam int OPER_SETTLED_BIT = 8;
    localparam int STD_OPC_BIT      = 0;
    localparam int STD_PON_BIT      = 7;
    localparam int STB_QUES_BIT     = 3;
    localparam int STB_MAV_BIT      = 4;
    localparam int STB_ESB_BIT      = 5;
    localparam int STB_RQS_BIT      = 6;
    localparam int STB_OPER_BIT     = 7;
    // =====================================================================
    // masks, reset values and replies
    localparam logic [STD_W-1:0]  STD_USED_MASK = 8'hbd;
    localparam logic [OPER_W-1:0] OPER_USED_MASK = 16'h0100;
    localparam logic [OPER_W-1:0] REG16_RST     = 16'h0000;
    localparam logic [STD_W-1:0]  REG8_RST      = 8'h00;
    localparam logic [15:0]       OPC_REPLY     = 16'h0001;
    // =====================================================================
    // error queue shape
    localparam int ERR_DEPTH = 20;
    localparam int ERR_CHARS = 80;
    localparam int ERR_IW    = 5;
    localparam int ERR_LW    = 7;
    // =====================================================================
    // status commands
    typedef enum logic [4:0] {
        ISR_CMD_CLS      = 5'h00, ISR_CMD_ESE_WR   = 5'h01,
        ISR_CMD_ESE_RD   = 5'h02, ISR_CMD_ESR_RD   = 5'h03,
        ISR_CMD_OPC      = 5'h04, ISR_CMD_OPC_RD   = 5'h05,
        ISR_CMD_PSC_WR   = 5'h06, ISR_CMD_PSC_RD   = 5'h07,
        ISR_CMD_SRE_WR   = 5'h08, ISR_CMD_SRE_RD   = 5'h09,
        ISR_CMD_PRESET   = 5'h0a, ISR_CMD_QCOND_RD = 5'h0b,
        ISR_CMD_QEVT_RD  = 5'h0c, ISR_CMD_QEN_WR   = 5'h0d,
        ISR_CMD_QEN_RD   = 5'h0e, ISR_CMD_OCOND_RD = 5'h0f,
        ISR_CMD_OEVT_RD  = 5'h10, ISR_CMD_OEN_WR   = 5'h11,
        ISR_CMD_OEN_RD   = 5'h12, ISR_CMD_ERR_RD   = 5'h13
    } isr_code_t;
    typedef struct packed {
        logic               valid;
        isr_code_t          code;
        logic [15:0]        data;
    } isr_cmd_t;
    typedef struct packed {
        logic [ERR_LW-1:0]      len;
        logic [ERR_CHARS*8-1:0] text;
    } isr_err_t;
    typedef struct packed {
        logic               valid;
        logic [15:0]        data;
        isr_err_t           err;
    } isr_rsp_t;
    typedef struct packed {
        logic                          por_pend;
        logic [OPER_W-1:0]             oper_cond;
        logic [OPER_W-1:0]             oper_evt;
        logic [OPER_W-1:0]             oper_en;
        logic [QUES_W-1:0]             ques_cond;
        logic [QUES_W-1:0]             ques_evt;
        logic [QUES_W-1:0]             ques_en;
        logic [STD_W-1:0]              std_evt;
        logic [STD_W-1:0]              std_en;
        logic [STB_W-1:0]              sre;
        logic [STB_W-1:0]              stb;
        logic                          srq;
        logic                          psc;
        isr_rsp_t                      rsp;
        isr_err_t [ERR_DEPTH-1:0]      mem;
        logic [ERR_IW-1:0]             rd_idx;
        logic [ERR_IW-1:0]             wr_idx;
        logic [ERR_IW-1:0]             cnt;
    } isr_state_t;
endpackage

// ---- testbench/isr_host_model.sv ----
// Purpose: remote host controller that issues status commands
// Assumes: one command at a time, reply sampled one cycle after it
// Notes:   data lines are scrambled once a command is released
`timescale 1ns/1ps
module isr_host_model
(
    input  wire logic              sys_clk,
    input  wire isr_pkg::isr_rsp_t rsp,
    output      isr_pkg::isr_cmd_t cmd
);
    import isr_pkg::*;
    // =====================================================================
    // command port idles low until the first request
    initial cmd = '0;
    // one command: drive after an edge, hold for the taking edge, sample
    task automatic xfer(input isr_code_t code, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic got);
        @(posedge sys_clk);
        #1;
        cmd.valid = 1'b1;
        cmd.code  = code;
        cmd.data  = wdata;
        @(posedge sys_clk);
        #1;
        cmd.valid = 1'b0;
        cmd.data  = ~wdata;      // released data no longer holds its value
        rdata     = rsp.data;
        got       = rsp.valid;
    endtask
endmodule // isr_host_model

// ---- testbench/isr_top_tb_top.sv ----
// Purpose: self-checking bench for the status reporting block
// Assumes: host model drives commands, bench drives measurement inputs
// Notes:   all expectations are worked out from the status rules
`timescale 1ns/1ps
module isr_top_tb_top;
    import isr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    isr_cmd_t    cmd;
    logic        meas_done = 1'b0;
    logic        filter_on = 1'b0;
    logic        filter_settled = 1'b0;
    logic        err_push = 1'b0;
    isr_err_t    err_in = '0;
    logic        psc_saved = 1'b0;
    logic [7:0]  ese_saved = 8'h21;
    logic [7:0]  sre_saved = 8'h80;
    logic [15:0] ques_cond_in = 16'h0000;
    logic [7:0]  std_evt_set = 8'h00;
    logic        mav = 1'b0;
    isr_rsp_t    rsp;
    logic [7:0]  status_byte;
    logic [7:0]  ese_mask;
    logic        srq;
    logic        psc_flag;
    logic [7:0]  sre_mask;
    logic [4:0]  err_count;
    int          failures = 0;
    int          check_count = 0;
    // =====================================================================
    // clock and instances
    always #4 sys_clk = ~sys_clk;
    isr_host_model host (.sys_clk(sys_clk), .rsp(rsp), .cmd(cmd));
    isr_top uut (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
        .meas_done(meas_done), .filter_on(filter_on),
        .filter_settled(filter_settled), .ques_cond_in(ques_cond_in),
        .std_evt_set(std_evt_set), .mav(mav), .err_push(err_push),
        .err_in(err_in), .psc_saved(psc_saved), .ese_saved(ese_saved),
        .sre_saved(sre_saved), .rsp(rsp), .status_byte(status_byte),
        .srq(srq), .psc_flag(psc_flag), .ese_mask(ese_mask),
        .sre_mask(sre_mask), .err_count(err_count));
    // =====================================================================
    // shared helpers
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // query or write with reply, checks reply pulse and value
    task automatic q(input isr_code_t c, input logic [15:0] d,
                     input logic [15:0] exp);
        logic [15:0] rd;
        logic        got;
        host.xfer(c, d, rd, got);
        chk({15'h0000, got}, 16'h0001);
        chk(rd, exp);
    endtask
    // command that must give no reply
    task automatic act(input isr_code_t c);
        logic [15:0] rd;
        logic        got;
        host.xfer(c, 16'h0000, rd, got);
        chk({15'h0000, got}, 16'h0000);
    endtask
    task automatic meas(input logic on, input logic st);
        @(posedge sys_clk);
        #1;
        meas_done      = 1'b1;
        filter_on      = on;
        filter_settled = st;
        @(posedge sys_clk);
        #1;
        meas_done = 1'b0;
    endtask
    // new questionable levels plus a one-cycle standard event pulse
    task automatic evt_in(input logic [15:0] qc, input logic [7:0] se);
        @(posedge sys_clk);
        #1;
        ques_cond_in = qc;
        std_evt_set  = se;
        @(posedge sys_clk);
        #1;
        std_evt_set  = 8'h00;
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        #1;
        reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // =====================================================================
    // scenarios
    task automatic test_power_on;
        q(ISR_CMD_ESR_RD, 16'h0000, 16'h0080);
        q(ISR_CMD_ESR_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_ESE_RD, 16'h0000, 16'h0021);
        q(ISR_CMD_SRE_RD, 16'h0000, 16'h0080);
        q(ISR_CMD_OEN_RD, 16'h0000, 16'h0000);
        chk({8'h00, sre_mask}, 16'h0080);
        chk({15'h0000, psc_flag}, 16'h0000);
        $display("test power_on done");
    endtask
    task automatic test_operation;
        meas(1'b1, 1'b1);
        q(ISR_CMD_OCOND_RD, 16'h0000, 16'h0100);
        q(ISR_CMD_OEVT_RD, 16'h0000, 16'h0100);
        q(ISR_CMD_OEVT_RD, 16'h0000, 16'h0000);
        meas(1'b1, 1'b0);
        q(ISR_CMD_OCOND_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_OEVT_RD, 16'h0000, 16'h0000);
        meas(1'b0, 1'b1);
        q(ISR_CMD_OCOND_RD, 16'h0000, 16'h0000);
        meas(1'b1, 1'b1);
        meas(1'b1, 1'b1);
        q(ISR_CMD_OEVT_RD, 16'h0000, 16'h0100);
        $display("test operation done");
    endtask
    task automatic test_enable;
        meas(1'b1, 1'b0);
        meas(1'b1, 1'b1);
        q(ISR_CMD_OEN_WR, 16'h0100, 16'h0000);
        q(ISR_CMD_OEN_RD, 16'h0000, 16'h0100);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, status_byte[7]}, 16'h0001);
        q(ISR_CMD_OEN_WR, 16'h0000, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, status_byte[7]}, 16'h0000);
        q(ISR_CMD_QEN_WR, 16'h0201, 16'h0000);
        q(ISR_CMD_QEN_RD, 16'h0000, 16'h0201);
        q(ISR_CMD_OEN_WR, 16'h0100, 16'h0000);
        act(ISR_CMD_PRESET);
        q(ISR_CMD_QEN_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_OEN_RD, 16'h0000, 16'h0000);
        $display("test enable done");
    endtask
    task automatic test_clear;
        act(ISR_CMD_OPC);
        q(ISR_CMD_ESR_RD, 16'h0000, 16'h0001);
        q(ISR_CMD_OPC_RD, 16'h0000, 16'h0001);
        act(ISR_CMD_OPC);
        q(ISR_CMD_OEN_WR, 16'h0100, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, status_byte[7]}, 16'h0001);
        act(ISR_CMD_CLS);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, status_byte[7]}, 16'h0000);
        q(ISR_CMD_ESR_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_OEVT_RD, 16'h0000, 16'h0000);
        $display("test clear done");
    endtask
    // questionable and standard groups, request summary and masks
    task automatic test_groups;
        evt_in(16'h0201, 8'h46);
        mav = 1'b1;
        q(ISR_CMD_QCOND_RD, 16'h0000, 16'h0201);
        q(ISR_CMD_ESE_WR, 16'h0004, 16'h0000);
        q(ISR_CMD_QEN_WR, 16'h0001, 16'h0000);
        q(ISR_CMD_SRE_WR, 16'h0008, 16'h0000);
        chk({8'h00, status_byte}, 16'h0078);
        chk({15'h0000, srq}, 16'h0001);
        chk({8'h00, ese_mask}, 16'h0004);
        q(ISR_CMD_QEVT_RD, 16'h0000, 16'h0201);
        q(ISR_CMD_QEVT_RD, 16'h0000, 16'h0000);
        chk({8'h00, status_byte}, 16'h0030);
        chk({15'h0000, srq}, 16'h0000);
        q(ISR_CMD_ESR_RD, 16'h0000, 16'h0004);
        evt_in(16'h0201, 8'h04);
        chk({8'h00, status_byte}, 16'h0030);
        act(ISR_CMD_CLS);
        chk({8'h00, status_byte}, 16'h0010);
        chk({8'h00, sre_mask}, 16'h0008);
        mav = 1'b0;
        $display("test groups done");
    endtask
    task automatic test_errors;
        logic [15:0] rd;
        logic        got;
        @(posedge sys_clk);
        for (int i = 0; i < 21; i++)
        begin
            #1;
            err_push = 1'b1;
            err_in = '0;
            err_in.len = (i == 0) ? 7'd80 : 7'(i);
            err_in.text[7:0] = 8'(i);
            err_in.text[639:632] = 8'h5a;
            @(posedge sys_clk);
        end
        #1;
        err_push = 1'b0;
        @(posedge sys_clk);
        #1;
        chk({11'h000, err_count}, 16'h0014);
        for (int i = 0; i < 2; i++)
        begin
            host.xfer(ISR_CMD_ERR_RD, 16'h0000, rd, got);
            chk({9'h000, rsp.err.len}, (i == 0) ? 16'd80 : 16'(i));
            chk({8'h00, rsp.err.text[7:0]}, 16'(i));
            chk({8'h00, rsp.err.text[639:632]}, 16'h005a);
        end
        @(posedge sys_clk);
        #1;
        chk({11'h000, err_count}, 16'h0012);
        $display("test errors done");
    endtask
    task automatic test_psc_reset;
        q(ISR_CMD_PSC_WR, 16'h0001, 16'h0000);
        q(ISR_CMD_PSC_RD, 16'h0000, 16'h0001);
        q(ISR_CMD_OEN_WR, 16'h0100, 16'h0000);
        psc_saved = 1'b1;
        do_reset();
        q(ISR_CMD_ESE_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_SRE_RD, 16'h0000, 16'h0000);
        q(ISR_CMD_OEN_RD, 16'h0000, 16'h0000);
        chk({8'h00, ese_mask}, 16'h0000);
        chk({8'h00, sre_mask}, 16'h0000);
        chk({15'h0000, psc_flag}, 16'h0001);
        $display("test psc_reset done");
    endtask
    // =====================================================================
    // watchdog: whole run is well under this span
    initial
    begin
        #400000;
        failures++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge sys_clk);
        test_power_on();
        test_operation();
        test_enable();
        test_clear();
        test_groups();
        test_errors();
        test_psc_reset();
        report_and_stop();
    end
endmodule // isr_top_tb_top
